// file: src/iboeu_defs.svh
/*
  Offsets, field positions, reset values and codes of the integer and
  bit-operation execution unit. Assumes a 32-bit APB with byte addresses.
*/
`ifndef IBOEU_DEFS_SVH
`define IBOEU_DEFS_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IBOEU_OFF_CTRL 8'h00
`define IBOEU_OFF_SRC 8'h04
`define IBOEU_OFF_DST 8'h08
`define IBOEU_OFF_PARAM 8'h0c
`define IBOEU_OFF_DISP 8'h10
`define IBOEU_OFF_PC 8'h14
`define IBOEU_OFF_SP 8'h18
`define IBOEU_OFF_SR 8'h1c
`define IBOEU_OFF_RESULT 8'h20
`define IBOEU_OFF_STATUS 8'h24

// ----------------------------------------------------------------
// fields
// ----------------------------------------------------------------
`define IBOEU_CTRL_OP 4:0
`define IBOEU_P_NUM 5:0
`define IBOEU_P_OFFS 10:6
`define IBOEU_P_WID 16:11
`define IBOEU_P_COND 20:17
`define IBOEU_SR_C 0
`define IBOEU_SR_V 1
`define IBOEU_SR_Z 2
`define IBOEU_SR_N 3
`define IBOEU_SR_X 4
`define IBOEU_SR_S 13
`define IBOEU_ST_BUSY 0
`define IBOEU_ST_BADOP 1
`define IBOEU_ST_CAUSE 3:2

// ----------------------------------------------------------------
// values
// ----------------------------------------------------------------
`define IBOEU_SR_RST 16'h2700
`define IBOEU_COND_T 4'h0
`define IBOEU_COND_F 4'h1
`define IBOEU_SP_STEP 32'h0000_0004
`define IBOEU_FULL_W 6'h20
`define IBOEU_BCD_MAX 5'h09
`define IBOEU_BCD_ADJ 5'h06
`define IBOEU_CAUSE_NONE 2'h0
`define IBOEU_CAUSE_PRIV 2'h1
`define IBOEU_CAUSE_ILL 2'h2

`endif

// file: src/iboeu_pkg.sv
/*
  Types of the integer and bit-operation execution unit.
  Assumes the opcode is written as a 5-bit value by software.
*/
package iboeu_pkg;

  // operations, in the order software encodes them
  typedef enum logic [4:0] {
    op_decimal_add_extend, op_binary_add_extend, op_add, op_address_add,
    op_immediate_add, op_quick_add, op_and, op_immediate_and, op_and_ccr,
    op_and_sr, op_shift_left, op_shift_right, op_cond_branch,
    op_unconditional_branch, op_branch_to_subroutine, op_single_bit_change,
    op_single_bit_clear, op_single_bit_set, op_single_bit_test,
    op_field_invert, op_field_clear, op_field_set, op_field_extract_signed,
    op_field_extract_unsigned, op_field_find_first_one, op_field_insert,
    op_field_test, op_breakpoint_op
  } iboeu_op_e;

  typedef enum logic [0:0] {st_idle, st_ack} iboeu_state_e;

endpackage

// file: src/iboeu_exec_unit.sv
/*
  Integer and bit-operation execution unit behind an APB register file.
  Software loads operands, then writes an opcode to CTRL; the operation
  executes at that access edge. Assumes APB3 signalling, one clock.
*/
// The placing of the registers and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps
`include "iboeu_defs.svh"

// Contract
// - decimal add adds the packed bcd low bytes of source, destination and extend into the destination low byte.
// - binary add with extend sums source, destination and extend into destination.
// - plain add stores source plus destination; address add stores the same sum, flags unchanged.
// - immediate and quick add add immediate data to the destination.
// - logical and replaces destination with source and destination bitwise.
// - and to condition codes masks the condition code register in any state.
// - and to status register works only in supervisor state, else traps.
// - arithmetic shifts move destination by a count and store it back.
// - conditional branch adds displacement to pc when condition holds.
// - conditional branch refuses the always-true and always-false codes.
// - unconditional branch always adds displacement, no stack activity.
// - subroutine branch drops sp by four, pushes pc, then branches.
// - bit change puts inverted bit into zero flag, then inverts bit.
// - bit clear puts inverted bit into zero flag, then clears bit.
// - bit set puts inverted bit into zero flag, then sets bit.
// - bit test puts inverted bit into zero flag, destination unchanged.
// - field invert complements every bit of the selected field in place.
// - field clear writes zeros, field set writes ones; other bits kept.
// - field extracts copy the selected field into a data register.
// - find first one writes offset of first set field bit.
// - field insert writes low data register bits into the field.
// - field test sets condition codes, destination unchanged.
// - breakpoint runs an acknowledge cycle, then takes illegal-instruction trap.
module iboeu_exec_unit (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core side
  output logic stack_wr,
  output logic [31:0] stack_addr,
  output logic [31:0] stack_data,
  output logic breakpoint_op_ack_cycle,
  output logic trap_req,
  output logic [1:0] trap_cause
);

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rotr(input logic [31:0] x, input logic [4:0] n);
    rotr = (x >> n) | (x << (6'h20 - {1'b0, n}));
  endfunction

  function automatic logic [31:0] rotl(input logic [31:0] x, input logic [4:0] n);
    rotl = (x << n) | (x >> (6'h20 - {1'b0, n}));
  endfunction

  // condition test against c v z n of the condition codes
  function automatic logic cond_true(input logic [3:0] c, input logic [4:0] f);
    logic cc, vv, zz, nn;
    cc = f[`IBOEU_SR_C];
    vv = f[`IBOEU_SR_V];
    zz = f[`IBOEU_SR_Z];
    nn = f[`IBOEU_SR_N];
    case (c)
      4'h0: cond_true = 1'b1;
      4'h1: cond_true = 1'b0;
      4'h2: cond_true = ~cc & ~zz;
      4'h3: cond_true = cc | zz;
      4'h4: cond_true = ~cc;
      4'h5: cond_true = cc;
      4'h6: cond_true = ~zz;
      4'h7: cond_true = zz;
      4'h8: cond_true = ~vv;
      4'h9: cond_true = vv;
      4'ha: cond_true = ~nn;
      4'hb: cond_true = nn;
      4'hc: cond_true = ~(nn ^ vv);
      4'hd: cond_true = nn ^ vv;
      4'he: cond_true = ~(nn ^ vv) & ~zz;
      default: cond_true = zz | (nn ^ vv);
    endcase
  endfunction

  // index of first set bit from the top, or width when none
  function automatic logic [5:0] first_one(input logic [31:0] a, input logic [5:0] w);
    first_one = w;
    for (int i = 31; i >= 0; i--) begin
      if (a[31 - i] && (6'(i) < w)) begin
        first_one = 6'(i);
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [31:0] src, dst, param, disp, pc, sp, result;
  logic [15:0] sr;
  logic bad_op;
  logic [1:0] last_cause;
  iboeu_pkg::iboeu_state_e state;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  wire acc = psel & penable;
  wire setup = psel & ~penable;
  wire wr = acc & pwrite;
  wire hit_ctrl = paddr == `IBOEU_OFF_CTRL;
  wire hit_src = paddr == `IBOEU_OFF_SRC;
  wire hit_dst = paddr == `IBOEU_OFF_DST;
  wire hit_param = paddr == `IBOEU_OFF_PARAM;
  wire hit_disp = paddr == `IBOEU_OFF_DISP;
  wire hit_pc = paddr == `IBOEU_OFF_PC;
  wire hit_sp = paddr == `IBOEU_OFF_SP;
  wire hit_sr = paddr == `IBOEU_OFF_SR;
  wire hit_res = paddr == `IBOEU_OFF_RESULT;
  wire hit_stat = paddr == `IBOEU_OFF_STATUS;
  wire hit = hit_ctrl | hit_src | hit_dst | hit_param | hit_disp | hit_pc |
             hit_sp | hit_sr | hit_res | hit_stat;
  // a start during the breakpoint acknowledge cycle is dropped, busy shows why
  wire busy = state != iboeu_pkg::st_idle;
  wire start = wr & hit_ctrl & ~busy;
  wire op_legal = pwdata[`IBOEU_CTRL_OP] <= 5'(iboeu_pkg::op_breakpoint_op);
  wire [4:0] op_raw = pwdata[`IBOEU_CTRL_OP];
  iboeu_pkg::iboeu_op_e op;
  assign op = iboeu_pkg::iboeu_op_e'(op_raw);

  // zero-wait slave; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;

  wire [31:0] status_word = {28'h0, last_cause, bad_op, busy};
  wire [31:0] rd_mux =
    hit_src ? src : hit_dst ? dst : hit_param ? param : hit_disp ? disp :
    hit_pc ? pc : hit_sp ? sp : hit_sr ? {16'h0, sr} :
    hit_res ? result : hit_stat ? status_word : 32'h0;

  // ----------------------------------------------------------------
  // operand fields
  // ----------------------------------------------------------------
  wire [4:0] bitn = param[4:0];
  wire [5:0] cnt = param[`IBOEU_P_NUM];
  wire [4:0] fo = param[`IBOEU_P_OFFS];
  wire [5:0] fw = (param[`IBOEU_P_WID] == 6'h0) ? `IBOEU_FULL_W : param[`IBOEU_P_WID];
  wire [3:0] cond = param[`IBOEU_P_COND];
  wire [4:0] condition_code_register = sr[4:0];
  wire xf = sr[`IBOEU_SR_X];
  wire sel_bit = dst[bitn];
  // field taken msb-first from the offset, wrapping round the word
  wire [31:0] top_mask = ~(32'hffff_ffff >> fw);
  wire [31:0] fmask = rotr(top_mask, fo);
  wire [31:0] fld_al = rotl(dst, fo) & top_mask;
  wire [5:0] rsh = 6'h20 - fw;
  wire [31:0] fld_u = fld_al >> rsh;
  wire [31:0] fld_s = 32'($signed(fld_al) >>> rsh);
  wire [31:0] ins = rotr(src << rsh, fo) & fmask;
  wire [5:0] ffo = first_one(fld_al, fw);
  // sums
  wire [32:0] sum_x = {1'b0, src} + {1'b0, dst} + {32'h0, xf};
  wire [32:0] sum_p = {1'b0, src} + {1'b0, dst};
  // packed decimal on the low byte
  wire [4:0] lo5 = {1'b0, src[3:0]} + {1'b0, dst[3:0]} + {4'h0, xf};
  wire lo_c = lo5 > `IBOEU_BCD_MAX;
  wire [4:0] lo_a = lo_c ? lo5 + `IBOEU_BCD_ADJ : lo5;
  wire [4:0] hi5 = {1'b0, src[7:4]} + {1'b0, dst[7:4]} + {4'h0, lo_c};
  wire hi_c = hi5 > `IBOEU_BCD_MAX;
  wire [4:0] hi_a = hi_c ? hi5 + `IBOEU_BCD_ADJ : hi5;
  wire [7:0] bcd = {hi_a[3:0], lo_a[3:0]};
  // arithmetic shifts
  wire [63:0] shl = {32'h0, dst} << cnt;
  wire [63:0] shr = 64'($signed({dst, 32'h0}) >>> cnt);
  wire shl_v = 32'($signed(shl[31:0]) >>> cnt) != dst;

  // ----------------------------------------------------------------
  // execute
  // ----------------------------------------------------------------
  logic [31:0] next_dst, next_res, next_pc, next_sp;
  logic [15:0] next_sr;
  logic do_push, do_trap, do_breakpoint_op;
  logic [1:0] next_cause;

  // flag update for results that set n and z and clear v and c
  function automatic logic [15:0] nz(input logic [15:0] s, input logic [31:0] r);
    nz = s;
    nz[`IBOEU_SR_N] = r[31];
    nz[`IBOEU_SR_Z] = r == 32'h0;
    nz[`IBOEU_SR_V] = 1'b0;
    nz[`IBOEU_SR_C] = 1'b0;
  endfunction

  // flag update for additions
  function automatic logic [15:0] addf(input logic [15:0] s, input logic [31:0] a,
                                       input logic [31:0] b, input logic [32:0] r,
                                       input logic sticky_z);
    addf = s;
    addf[`IBOEU_SR_N] = r[31];
    addf[`IBOEU_SR_Z] = sticky_z ? (s[`IBOEU_SR_Z] & (r[31:0] == 32'h0)) :
                                   (r[31:0] == 32'h0);
    addf[`IBOEU_SR_V] = (a[31] == b[31]) & (r[31] != a[31]);
    addf[`IBOEU_SR_C] = r[32];
    addf[`IBOEU_SR_X] = r[32];
  endfunction

  always_comb begin
    next_dst = dst;
    next_res = result;
    next_pc = pc;
    next_sp = sp;
    next_sr = sr;
    do_push = 1'b0;
    do_trap = 1'b0;
    do_breakpoint_op = 1'b0;
    next_cause = `IBOEU_CAUSE_NONE;
    unique case (op)
      iboeu_pkg::op_decimal_add_extend: begin
        next_dst = {dst[31:8], bcd};
        next_sr[`IBOEU_SR_C] = hi_c;
        next_sr[`IBOEU_SR_X] = hi_c;
        next_sr[`IBOEU_SR_Z] = sr[`IBOEU_SR_Z] & (bcd == 8'h0);
      end
      iboeu_pkg::op_binary_add_extend: begin
        next_dst = sum_x[31:0];
        next_sr = addf(sr, src, dst, sum_x, 1'b1);
      end
      iboeu_pkg::op_add, iboeu_pkg::op_immediate_add, iboeu_pkg::op_quick_add: begin
        next_dst = sum_p[31:0];
        next_sr = addf(sr, src, dst, sum_p, 1'b0);
      end
      iboeu_pkg::op_address_add: next_dst = sum_p[31:0];
      iboeu_pkg::op_and, iboeu_pkg::op_immediate_and: begin
        next_dst = src & dst;
        next_sr = nz(sr, src & dst);
      end
      iboeu_pkg::op_and_ccr: next_sr[4:0] = condition_code_register & src[4:0];
      iboeu_pkg::op_and_sr: begin
        // user state leaves the status register alone and traps
        if (sr[`IBOEU_SR_S]) begin
          next_sr = sr & src[15:0];
        end else begin
          do_trap = 1'b1;
          next_cause = `IBOEU_CAUSE_PRIV;
        end
      end
      iboeu_pkg::op_shift_left: begin
        next_dst = shl[31:0];
        next_sr = nz(sr, shl[31:0]);
        next_sr[`IBOEU_SR_V] = shl_v;
        next_sr[`IBOEU_SR_C] = (cnt != 6'h0) & shl[32];
        if (cnt != 6'h0) next_sr[`IBOEU_SR_X] = shl[32];
      end
      iboeu_pkg::op_shift_right: begin
        next_dst = shr[63:32];
        next_sr = nz(sr, shr[63:32]);
        next_sr[`IBOEU_SR_C] = (cnt != 6'h0) & shr[31];
        if (cnt != 6'h0) next_sr[`IBOEU_SR_X] = shr[31];
      end
      iboeu_pkg::op_cond_branch: begin
        // always-true and always-false are refused as illegal
        if (cond == `IBOEU_COND_T || cond == `IBOEU_COND_F) begin
          do_trap = 1'b1;
          next_cause = `IBOEU_CAUSE_ILL;
        end else if (cond_true(cond, condition_code_register)) begin
          next_pc = pc + disp;
        end
      end
      iboeu_pkg::op_unconditional_branch: next_pc = pc + disp;
      iboeu_pkg::op_branch_to_subroutine: begin
        next_sp = sp - `IBOEU_SP_STEP;
        do_push = 1'b1;
        next_pc = pc + disp;
      end
      iboeu_pkg::op_single_bit_change: begin
        next_sr[`IBOEU_SR_Z] = ~sel_bit;
        next_dst[bitn] = ~sel_bit;
      end
      iboeu_pkg::op_single_bit_clear: begin
        next_sr[`IBOEU_SR_Z] = ~sel_bit;
        next_dst[bitn] = 1'b0;
      end
      iboeu_pkg::op_single_bit_set: begin
        next_sr[`IBOEU_SR_Z] = ~sel_bit;
        next_dst[bitn] = 1'b1;
      end
      iboeu_pkg::op_single_bit_test: next_sr[`IBOEU_SR_Z] = ~sel_bit;
      iboeu_pkg::op_field_invert: begin
        next_dst = dst ^ fmask;
        next_sr = nz(sr, fld_al);
      end
      iboeu_pkg::op_field_clear: begin
        next_dst = dst & ~fmask;
        next_sr = nz(sr, fld_al);
      end
      iboeu_pkg::op_field_set: begin
        next_dst = dst | fmask;
        next_sr = nz(sr, fld_al);
      end
      iboeu_pkg::op_field_extract_signed: begin
        next_res = fld_s;
        next_sr = nz(sr, fld_al);
      end
      iboeu_pkg::op_field_extract_unsigned: begin
        next_res = fld_u;
        next_sr = nz(sr, fld_al);
      end
      iboeu_pkg::op_field_find_first_one: begin
        next_res = {26'h0, ffo} + {27'h0, fo};
        next_sr = nz(sr, fld_al);
      end
      iboeu_pkg::op_field_insert: begin
        next_dst = (dst & ~fmask) | ins;
        next_sr = nz(sr, rotl(ins, fo));
      end
      iboeu_pkg::op_field_test: next_sr = nz(sr, fld_al);
      iboeu_pkg::op_breakpoint_op: do_breakpoint_op = 1'b1;
      default: begin
      end
    endcase
  end

  wire go = start & op_legal;

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  // operand and parameter registers, software only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src <= 32'h0;
      param <= 32'h0;
      disp <= 32'h0;
    end else begin
      if (wr & hit_src) src <= pwdata;
      if (wr & hit_param) param <= pwdata;
      if (wr & hit_disp) disp <= pwdata;
    end
  end

  // architectural state: software writes, or the executed operation
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dst <= 32'h0;
      result <= 32'h0;
      pc <= 32'h0;
      sp <= 32'h0;
      sr <= `IBOEU_SR_RST;
    end else if (go) begin
      dst <= next_dst;
      result <= next_res;
      pc <= next_pc;
      sp <= next_sp;
      sr <= next_sr;
    end else begin
      if (wr & hit_dst) dst <= pwdata;
      if (wr & hit_pc) pc <= pwdata;
      if (wr & hit_sp) sp <= pwdata;
      if (wr & hit_sr) sr <= pwdata[15:0];
    end
  end

  // breakpoint sequencer: acknowledge first, trap one cycle later
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= iboeu_pkg::st_idle;
    end else if (go & do_breakpoint_op) begin
      state <= iboeu_pkg::st_ack;
    end else begin
      state <= iboeu_pkg::st_idle;
    end
  end

  // event outputs; strobes are one-cycle pulses, stack address and data hold until the next push
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stack_wr <= 1'b0;
      stack_addr <= 32'h0;
      stack_data <= 32'h0;
      breakpoint_op_ack_cycle <= 1'b0;
      trap_req <= 1'b0;
      trap_cause <= `IBOEU_CAUSE_NONE;
    end else begin
      stack_wr <= go & do_push;
      if (go & do_push) stack_addr <= next_sp;
      if (go & do_push) stack_data <= pc;
      breakpoint_op_ack_cycle <= go & do_breakpoint_op;
      trap_req <= (go & do_trap) | breakpoint_op_ack_cycle;
      trap_cause <= breakpoint_op_ack_cycle ? `IBOEU_CAUSE_ILL :
                    (go & do_trap) ? next_cause : `IBOEU_CAUSE_NONE;
    end
  end

  // status and read data; read data is sampled in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
      bad_op <= 1'b0;
      last_cause <= `IBOEU_CAUSE_NONE;
    end else begin
      if (setup & ~pwrite) prdata <= rd_mux;
      if (start) bad_op <= ~op_legal;
      if (trap_req) last_cause <= trap_cause;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  wire is_op_bsr = go & (op == iboeu_pkg::op_branch_to_subroutine);
  wire is_op_bra = go & (op == iboeu_pkg::op_unconditional_branch);
  wire is_op_bcc = go & (op == iboeu_pkg::op_cond_branch);

  AST_BSR_PUSH: assert property (is_op_bsr |=> stack_wr &&
    stack_addr == $past(sp) - `IBOEU_SP_STEP && stack_data == $past(pc) &&
    sp == stack_addr) else $error("subroutine push wrong");
  AST_BRA_JUMP: assert property (is_op_bra |=> pc == $past(pc) + $past(disp) &&
    sp == $past(sp) && !stack_wr) else $error("branch wrong");
  AST_BCC_RESERVED: assert property (is_op_bcc && cond <= `IBOEU_COND_F |=>
    pc == $past(pc) && trap_req && trap_cause == `IBOEU_CAUSE_ILL)
    else $error("reserved condition accepted");
  AST_SR_USER: assert property (go && op == iboeu_pkg::op_and_sr &&
    !sr[`IBOEU_SR_S] |=> sr == $past(sr) && trap_req &&
    trap_cause == `IBOEU_CAUSE_PRIV) else $error("user status write");
  AST_BREAKPOINT_OP_SEQ: assert property (go && op == iboeu_pkg::op_breakpoint_op |=>
    breakpoint_op_ack_cycle && !trap_req ##1 trap_req && trap_cause == `IBOEU_CAUSE_ILL)
    else $error("breakpoint sequence wrong");
  AST_SINGLE_BIT_TEST_Z: assert property (go && op == iboeu_pkg::op_single_bit_test |=>
    dst == $past(dst) && sr[`IBOEU_SR_Z] != dst[$past(bitn)])
    else $error("bit test wrong");
  AST_SINGLE_BIT_CLEAR_BIT: assert property (go && op == iboeu_pkg::op_single_bit_clear |=>
    !dst[$past(bitn)] && sr[`IBOEU_SR_Z] == !$past(sel_bit))
    else $error("bit clear wrong");
  AST_ADD_SUM: assert property (go && op == iboeu_pkg::op_add |=>
    dst == $past(src) + $past(dst)) else $error("add sum wrong");
  AST_CCR_AND: assert property (go && op == iboeu_pkg::op_and_ccr |=>
    sr[4:0] == ($past(src[4:0]) & $past(condition_code_register)) && !trap_req)
    else $error("ccr and wrong");

  COV_BSR: cover property (is_op_bsr ##1 stack_wr);
  COV_BREAKPOINT_OP: cover property (breakpoint_op_ack_cycle ##1 trap_req);
  COV_BCC_TAKEN: cover property (is_op_bcc && next_pc != pc);

endmodule

// file: tb/iboeu_exec_unit_tb.sv
/*
  Self-checking bench of the execution unit: APB driver and result model.
  Assumes the register map and opcode order of the unit's header and package.
*/
`timescale 1ns/10ps
`include "iboeu_defs.svh"
module iboeu_exec_unit_tb;
  // ------------------------------------------------------------
  // signals and counters
  // ------------------------------------------------------------
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, src, dst, prm, exp, fv, pcv, ev, iv;
  logic pready, pslverr, stack_wr, breakpoint_op_ack_cycle, trap_req, last_err;
  logic [31:0] stack_addr, stack_data;
  logic [1:0] trap_cause, cause_seen;
  int err_total = 0, checks_done = 0, cyc = 0, n_push = 0, n_breakpoint_op = 0, n_trap = 0;
  int t_breakpoint_op = 0, t_trap = 0, b, o, w, c, ff;
  initial forever #50 pclk = ~pclk;
  iboeu_exec_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .stack_wr(stack_wr), .stack_addr(stack_addr),
    .stack_data(stack_data), .breakpoint_op_ack_cycle(breakpoint_op_ack_cycle), .trap_req(trap_req),
    .trap_cause(trap_cause));
  // event counters; pulses last one cycle, so each edge counts one event
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (stack_wr === 1'b1) n_push <= n_push + 1;
    if (breakpoint_op_ack_cycle === 1'b1) t_breakpoint_op <= cyc;
    if (breakpoint_op_ack_cycle === 1'b1) n_breakpoint_op <= n_breakpoint_op + 1;
    if (trap_req === 1'b1) begin
      n_trap <= n_trap + 1;
      t_trap <= cyc;
      cause_seen <= trap_cause;
    end
    if (cyc == 20000) begin
      err_total++;
      conclude();
    end
  end
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    checks_done++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  // one transfer; an idle edge follows so strobes never change twice at once
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic load(input logic [31:0] s, input logic [31:0] d, input logic [31:0] p);
    src = s;
    dst = d;
    prm = p;
    apb(1'b1, `IBOEU_OFF_SRC, s);
    apb(1'b1, `IBOEU_OFF_DST, d);
    apb(1'b1, `IBOEU_OFF_PARAM, p);
  endtask
  // start an operation and give its pulses time to appear
  task automatic run(input int op);
    apb(1'b1, `IBOEU_OFF_CTRL, 32'(op));
    repeat (3) @(posedge pclk);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h9e35077f));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, `IBOEU_OFF_SR, 32'h0);
    chk(rd, 32'h2700);
    apb(1'b0, 8'h40, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    // opcodes 2, 1, 6, 5, 4, 3: add, add with extend, and, quick, immediate, address add
    for (int k = 0; k < 6; k++) begin
      apb(1'b1, `IBOEU_OFF_SR, 32'h2710);
      load($urandom, $urandom, 32'h0);
      run(k == 1 ? 1 : k == 2 ? 6 : k == 0 ? 2 : 8 - k);
      apb(1'b0, `IBOEU_OFF_DST, 32'h0);
      ev = k == 1 ? src + dst + 1 : k == 2 ? src & dst : src + dst;
      chk(rd, ev);
    end
    // packed decimal digits with extend set, then both arithmetic shifts
    for (int k = 0; k < 3; k++) begin
      b = $urandom_range(99, 0);
      o = $urandom_range(99, 0);
      w = $urandom_range(31, 0);
      c = b + o + 1;
      fv = 32'(b / 10 * 16 + b % 10);
      pcv = ($urandom & 32'hffff_ff00) | 32'(o / 10 * 16 + o % 10);
      apb(1'b1, `IBOEU_OFF_SR, 32'h2710);
      load(fv, pcv, 32'(w));
      run(k == 0 ? int'(iboeu_pkg::op_decimal_add_extend) : iboeu_pkg::op_shift_left + k - 1);
      apb(1'b0, `IBOEU_OFF_DST, 32'h0);
      ev = k == 1 ? dst << w : 32'($signed(dst) >>> w);
      if (k == 0) ev = {dst[31:8], 8'(c % 100 / 10 * 16 + c % 10)};
      chk(rd, ev);
    end
    $display("test arithmetic done");
    for (int k = 0; k < 4; k++) begin
      load($urandom, $urandom, $urandom_range(63, 0));
      run(iboeu_pkg::op_single_bit_change + k);
      exp = 32'h1 << (prm % 32);
      apb(1'b0, `IBOEU_OFF_SR, 32'h0);
      chk({31'h0, rd[`IBOEU_SR_Z]}, {31'h0, ~|(dst & exp)});
      apb(1'b0, `IBOEU_OFF_DST, 32'h0);
      ev = k == 0 ? dst ^ exp : k == 1 ? dst & ~exp : k == 2 ? dst | exp : dst;
      chk(rd, ev);
    end
    $display("test single bit done");
    // every field operation in opcode order, from invert through test
    for (int k = 0; k < 8; k++) begin
      o = $urandom_range(31, 0);
      w = $urandom_range(31, 1);
      load($urandom, $urandom, (w << 11) | (o << 6));
      run(iboeu_pkg::op_field_invert + k);
      exp = 32'h0;
      fv = 32'h0;
      iv = dst;
      ff = o + w;
      for (int i = 0; i < w; i++) begin
        exp[31 - (o + i) % 32] = 1'b1;
        fv = {fv[30:0], dst[31 - (o + i) % 32]};
        iv[31 - (o + i) % 32] = src[w - 1 - i];
        if (dst[31 - (o + i) % 32] && ff == o + w) ff = o + i;
      end
      apb(1'b0, (k > 2 && k < 6) ? `IBOEU_OFF_RESULT : `IBOEU_OFF_DST, 32'h0);
      ev = k == 0 ? dst ^ exp : k == 1 ? dst & ~exp : k == 2 ? dst | exp : k == 4 ? fv : dst;
      if (k == 3) ev = 32'($signed(fv << (32 - w)) >>> (32 - w));
      if (k == 5) ev = 32'(ff);
      if (k == 6) ev = iv;
      chk(rd, ev);
      if (k == 7) begin
        apb(1'b0, `IBOEU_OFF_SR, 32'h0);
        chk({31'h0, rd[`IBOEU_SR_Z]}, {31'h0, fv == 32'h0});
      end
    end
    $display("test bit field done");
    pcv = $urandom;
    dst = $urandom;
    fv = $urandom;
    apb(1'b1, `IBOEU_OFF_PC, pcv);
    apb(1'b1, `IBOEU_OFF_SP, dst);
    apb(1'b1, `IBOEU_OFF_DISP, fv);
    b = n_push;
    run(iboeu_pkg::op_branch_to_subroutine);
    chk(32'(n_push - b), 32'h1);
    chk(stack_addr, dst - 32'h4);
    chk(stack_data, pcv);
    apb(1'b0, `IBOEU_OFF_SP, 32'h0);
    chk(rd, dst - 32'h4);
    run(iboeu_pkg::op_unconditional_branch);
    apb(1'b0, `IBOEU_OFF_PC, 32'h0);
    chk(rd, pcv + fv + fv);
    chk(32'(n_push - b), 32'h1);
    for (int k = 0; k < 4; k++) begin
      c = k < 2 ? k : 9 - k;
      apb(1'b1, `IBOEU_OFF_SR, 32'h2704);
      load(32'h0, 32'h0, c << 17);
      apb(1'b0, `IBOEU_OFF_PC, 32'h0);
      pcv = rd;
      b = n_trap;
      run(iboeu_pkg::op_cond_branch);
      apb(1'b0, `IBOEU_OFF_PC, 32'h0);
      chk(rd, c == 7 ? pcv + fv : pcv);
      chk(32'(n_trap - b), k < 2 ? 32'h1 : 32'h0);
    end
    $display("test branches done");
    apb(1'b1, `IBOEU_OFF_SR, 32'h001f);
    load(32'h0005, 32'h0, 32'h0);
    run(iboeu_pkg::op_and_ccr);
    b = n_trap;
    run(iboeu_pkg::op_and_sr);
    apb(1'b0, `IBOEU_OFF_SR, 32'h0);
    chk(rd, 32'h0005);
    chk({30'h0, cause_seen}, 32'h1);
    b = n_breakpoint_op;
    run(iboeu_pkg::op_breakpoint_op);
    chk(32'(n_breakpoint_op - b), 32'h1);
    chk(32'(t_trap - t_breakpoint_op), 32'h1);
    chk({30'h0, cause_seen}, 32'h2);
    $display("test privilege and breakpoint done");
    conclude();
  end
endmodule
